// ===== hdl/ivm_vector_map.sv
// module: maps reset and interrupt sources to program vector addresses
`timescale 1ns/1ps

// Notes on behaviour
// - large variant two words, others one
// - small variant resets at zero, fixed table
// - larger variants reset address follows fuse
// - larger variants table base follows relocate bit
// - vector one is shared reset entry
// - external requests zero, one at slots 2,3
// - pin change requests at slots 4 to 6
// - watchdog timeout at slot 7
// - timer2 sources at slots 8 to 10
// - timer1 sources at slots 11 to 14
// - timer0 sources at slots 15 to 17
// - serial peripheral done at slot 18
// - uart sources at slots 19 to 21
// - converter 22, eeprom ready 23
// - comparator, two wire, self program 24-26
// - relocated vector is boot base plus entry
// - fuse gives boot reset, relocated vectors +1
// - fuse zero programmed, one unprogrammed
module ivm_vector_map (
  input wire logic clk,
  input wire logic reset,
  input wire ivm_pkg::ivm_cfg_t cfg,
  input wire logic reset_fetch,
  input wire logic [ivm_pkg::IVM_NUM_IRQ-1:0] irq_pending,
  input wire logic irq_accept,
  output ivm_pkg::ivm_vec_t vec_out
);
  import ivm_pkg::*;

  // =====================================================
  // helper functions

  // slot address: base plus slot size times (n-1)
  function automatic logic [12:0] slot_addr(input ivm_variant_t v, input logic [12:0] base,
                                            input logic [4:0] num);
    logic [12:0] idx;
    idx = {8'h00, num - 5'h01};
    if (v == IVM_VAR_LARGE) begin
      slot_addr = base + {idx[11:0], 1'b0};
    end else begin
      slot_addr = base + idx;
    end
  endfunction

  // lowest set request index gives the vector number
  function automatic logic [4:0] pick_lowest(input logic [IVM_NUM_IRQ-1:0] req);
    logic [4:0] n;
    n = 5'h00;
    for (int i = IVM_NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        n = 5'(i + 2);
      end
    end
    pick_lowest = n;
  endfunction

  // =====================================================
  // base and reset address selection
  logic has_boot;               // variant owns a boot section
  logic fuse_programmed;        // decoded boot reset fuse
  logic [12:0] reset_addr;      // reset fetch address
  logic [12:0] table_base;      // interrupt table start minus one slot

  // boot/relocate decode
  always_comb begin
    // small variant has no boot section
    has_boot = (cfg.variant != IVM_VAR_SMALL);
    fuse_programmed = (cfg.boot_reset_select_fuse == IVM_FUSE_PROGRAMMED);
    if (has_boot && fuse_programmed) begin
      reset_addr = cfg.boot_reset_addr;
    end else begin
      reset_addr = IVM_RESET_ADDR;
    end
    if (has_boot && cfg.vector_relocate_bit) begin
      table_base = cfg.boot_reset_addr + IVM_TABLE_BASE;
    end else begin
      table_base = IVM_TABLE_BASE;
    end
  end

  // =====================================================
  // request selection and output register
  logic [4:0] win_num;          // vector chosen among pending
  ivm_vec_t vec_d;              // next output
  ivm_vec_t vec_q;              // registered output

  // next vector output
  always_comb begin
    // lowest number wins; ..order of sources
    win_num = pick_lowest(irq_pending);
    vec_d = '0;
    vec_d.addr = vec_q.addr;
    vec_d.vec_num = vec_q.vec_num;
    vec_d.is_reset = vec_q.is_reset;
    if (reset_fetch) begin
      vec_d.valid = 1'b1;
      vec_d.is_reset = 1'b1;
      vec_d.vec_num = IVM_RESET_VEC_NUM;
      vec_d.addr = reset_addr;
    end else if (irq_accept && (win_num != 5'h00)) begin
      // interrupt entry: relocated slot n at base + slot(n)
      vec_d.valid = 1'b1;
      vec_d.is_reset = 1'b0;
      vec_d.vec_num = win_num;
      vec_d.addr = slot_addr(cfg.variant, table_base, win_num);
    end
  end

  // output register
  always_ff @(posedge clk) begin
    if (reset) begin
      vec_q <= '0;
    end else begin
      vec_q <= vec_d;
    end
  end

  assign vec_out = vec_q;

  // =====================================================
  // qualifiers shared by the checks
  logic flat_table;             // one-word slots with the table at zero
  logic accept_only;            // interrupt entry without a reset request

  // layout and request qualifiers used by the properties
  always_comb begin
    flat_table = (cfg.variant == IVM_VAR_SMALL)
      || (cfg.variant == IVM_VAR_MID && !cfg.vector_relocate_bit);
    accept_only = !reset_fetch && irq_accept;
  end

  // =====================================================
  // checks

  // reset entry always carries vector one
  property p_reset_vec;
    @(posedge clk) disable iff (reset)
      reset_fetch |=> (vec_out.valid && vec_out.is_reset && vec_out.vec_num == 5'h01);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset entry not vector one");

  // small variant resets at zero
  property p_small_reset;
    @(posedge clk) disable iff (reset)
      (reset_fetch && cfg.variant == IVM_VAR_SMALL) |=> (vec_out.addr == 13'h0000);
  endproperty
  a_small_reset: assert property (p_small_reset) else $error("small reset not zero");

  // programmed fuse selects boot reset address
  property p_fuse_reset;
    @(posedge clk) disable iff (reset)
      (reset_fetch && cfg.variant != IVM_VAR_SMALL && !cfg.boot_reset_select_fuse)
        |=> (vec_out.addr == $past(cfg.boot_reset_addr));
  endproperty
  a_fuse_reset: assert property (p_fuse_reset) else $error("boot reset not taken");

  // unprogrammed fuse resets at zero
  property p_fuse_unprog;
    @(posedge clk) disable iff (reset)
      (reset_fetch && cfg.boot_reset_select_fuse) |=> (vec_out.addr == 13'h0000);
  endproperty
  a_fuse_unprog: assert property (p_fuse_unprog) else $error("unprogrammed fuse moved reset");

  // external zero lands at one, unrelocated one-word layout
  property p_ext_zero;
    @(posedge clk) disable iff (reset)
      (!reset_fetch && irq_accept && irq_pending[0] && cfg.variant != IVM_VAR_LARGE
       && (cfg.variant == IVM_VAR_SMALL || !cfg.vector_relocate_bit))
        |=> (vec_out.addr == 13'h0001 && vec_out.vec_num == 5'h02);
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("external zero slot wrong");

  // pending lowest wins
  property p_priority;
    @(posedge clk) disable iff (reset)
      (!reset_fetch && irq_accept && irq_pending[1] && !irq_pending[0])
        |=> (vec_out.vec_num == 5'h03);
  endproperty
  a_priority: assert property (p_priority) else $error("priority order broken");

  // self-program ready alone lands at last slot in the large layout
  property p_large_last;
    @(posedge clk) disable iff (reset)
      (!reset_fetch && irq_accept && irq_pending == 25'h1000000
       && cfg.variant == IVM_VAR_LARGE && !cfg.vector_relocate_bit)
        |=> (vec_out.addr == 13'h0032);
  endproperty
  a_large_last: assert property (p_large_last) else $error("two word slot wrong");

  // relocation adds boot start
  property p_reloc;
    @(posedge clk) disable iff (reset)
      (!reset_fetch && irq_accept && irq_pending[6] && irq_pending[5:0] == 6'h00
       && cfg.variant == IVM_VAR_MID && cfg.vector_relocate_bit)
        |=> (vec_out.addr == $past(cfg.boot_reset_addr) + 13'h0007);
  endproperty
  a_reloc: assert property (p_reloc) else $error("relocated address wrong");

  // answer is a single-cycle pulse without a request
  property p_pulse;
    @(posedge clk) disable iff (reset)
      (!reset_fetch && !irq_accept) |=> !vec_out.valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("spurious valid");

  // external one lands at slot three
  property p_ext_one;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0000002)
        |=> (vec_out.addr == 13'h0002 && vec_out.vec_num == 5'h03);
  endproperty
  a_ext_one: assert property (p_ext_one) else $error("external one slot wrong");

  // pin change two lands at slot six
  property p_pin_change;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0000010)
        |=> (vec_out.addr == 13'h0005 && vec_out.vec_num == 5'h06);
  endproperty
  a_pin_change: assert property (p_pin_change) else $error("pin change slot wrong");

  // watchdog timeout lands at slot seven
  property p_watchdog;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0000020)
        |=> (vec_out.addr == 13'h0006 && vec_out.vec_num == 5'h07);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog slot wrong");

  // timer2 overflow lands at slot ten
  property p_timer2;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0000100)
        |=> (vec_out.addr == 13'h0009 && vec_out.vec_num == 5'h0a);
  endproperty
  a_timer2: assert property (p_timer2) else $error("timer2 slot wrong");

  // timer1 capture lands at slot eleven
  property p_timer1;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0000200)
        |=> (vec_out.addr == 13'h000a && vec_out.vec_num == 5'h0b);
  endproperty
  a_timer1: assert property (p_timer1) else $error("timer1 slot wrong");

  // timer0 overflow lands at slot seventeen
  property p_timer0;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0008000)
        |=> (vec_out.addr == 13'h0010 && vec_out.vec_num == 5'h11);
  endproperty
  a_timer0: assert property (p_timer0) else $error("timer0 slot wrong");

  // serial peripheral done lands at slot eighteen
  property p_spi;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0010000)
        |=> (vec_out.addr == 13'h0011 && vec_out.vec_num == 5'h12);
  endproperty
  a_spi: assert property (p_spi) else $error("serial done slot wrong");

  // uart receive lands at slot nineteen
  property p_uart;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0020000)
        |=> (vec_out.addr == 13'h0012 && vec_out.vec_num == 5'h13);
  endproperty
  a_uart: assert property (p_uart) else $error("uart slot wrong");

  // eeprom ready lands at slot twenty-three
  property p_eeprom;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0200000)
        |=> (vec_out.addr == 13'h0016 && vec_out.vec_num == 5'h17);
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("eeprom slot wrong");

  // two wire lands at slot twenty-five
  property p_two_wire;
    @(posedge clk) disable iff (reset)
      (accept_only && flat_table && irq_pending == 25'h0800000)
        |=> (vec_out.addr == 13'h0018 && vec_out.vec_num == 5'h19);
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two wire slot wrong");

  // relocate bit moves the large table into the boot section
  property p_reloc_large;
    @(posedge clk) disable iff (reset)
      (accept_only && cfg.variant == IVM_VAR_LARGE && cfg.vector_relocate_bit
       && irq_pending == 25'h0000002) |=> (vec_out.addr == $past(cfg.boot_reset_addr) + 13'h0004);
  endproperty
  a_reloc_large: assert property (p_reloc_large) else $error("large relocation wrong");

  // relocated table starts one past the boot reset address
  property p_reloc_start;
    @(posedge clk) disable iff (reset)
      (accept_only && cfg.variant == IVM_VAR_MID && cfg.vector_relocate_bit
       && irq_pending == 25'h0000001) |=> (vec_out.addr == $past(cfg.boot_reset_addr) + 13'h0001);
  endproperty
  a_reloc_start: assert property (p_reloc_start) else $error("relocated start wrong");

  // small variant ignores the relocate bit
  property p_small_fixed;
    @(posedge clk) disable iff (reset)
      (accept_only && cfg.variant == IVM_VAR_SMALL && irq_pending == 25'h0000001)
        |=> (vec_out.addr == 13'h0001);
  endproperty
  a_small_fixed: assert property (p_small_fixed) else $error("small table moved");

  // first large slot sits two words in
  property p_large_first;
    @(posedge clk) disable iff (reset)
      (accept_only && cfg.variant == IVM_VAR_LARGE && !cfg.vector_relocate_bit
       && irq_pending == 25'h0000001) |=> (vec_out.addr == 13'h0002 && vec_out.vec_num == 5'h02);
  endproperty
  a_large_first: assert property (p_large_first) else $error("large first slot wrong");

endmodule

// ===== hdl/ivm_pkg.sv
// package: constants and types for the interrupt vector map
package ivm_pkg;

  // =====================================================
  // sizes
  localparam int IVM_ADDR_W = 13;          // program word address width
  localparam int IVM_NUM_IRQ = 25;         // interrupt sources, vectors 2..26
  localparam int IVM_VEC_W = 5;            // width of a vector number

  // =====================================================
  // fixed addresses
  localparam logic [12:0] IVM_RESET_ADDR = 13'h0000;   // application reset entry
  localparam logic [12:0] IVM_TABLE_BASE = 13'h0000;   // normal table start
  localparam logic [12:0] IVM_BOOT_RESET_DEF = 13'h0f00; // boot reset address default
  localparam logic [12:0] IVM_BOOT_VEC_OFS = 13'h0001; // vectors sit one past boot reset
  localparam logic [4:0] IVM_RESET_VEC_NUM = 5'h01;   // vector number of reset

  // =====================================================
  // fuse encoding: zero means programmed
  localparam logic IVM_FUSE_PROGRAMMED = 1'b0;

  // variant of the memory size
  typedef enum logic [1:0] {
    IVM_VAR_SMALL,   // no boot section, one word slots
    IVM_VAR_MID,     // boot section, one word slots
    IVM_VAR_LARGE    // boot section, two word slots
  } ivm_variant_t;

  // configuration inputs that travel together
  typedef struct packed {
    ivm_variant_t variant;          // memory variant
    logic boot_reset_select_fuse;   // 0 = programmed
    logic vector_relocate_bit;      // relocation bit of core_control_register
    logic [12:0] boot_reset_addr;   // start of boot section
  } ivm_cfg_t;

  // vector answer to the core
  typedef struct packed {
    logic valid;                    // one-cycle pulse
    logic is_reset;                 // fetch is the reset entry
    logic [4:0] vec_num;            // vector number 1..26
    logic [12:0] addr;              // program word address
  } ivm_vec_t;

endpackage

// ===== test/ivm_core_model.sv
// core model: issues reset and interrupt entry requests
`timescale 1ns/1ps
module ivm_core_model (
  input wire logic clk,
  output logic reset_fetch,
  output logic irq_accept
);
  // ==========================================
  // request strobes rest low from time zero
  initial begin
    reset_fetch = 1'b0;
    irq_accept = 1'b0;
  end
  // one-cycle request, called at a falling edge
  // core enters vectors
  task automatic take(input logic rst, input logic irq);
    reset_fetch = rst;
    irq_accept = irq;
    @(negedge clk);
    reset_fetch = 1'b0;
    irq_accept = 1'b0;
  endtask
endmodule

// ===== test/testbench.sv
// self-checking bench for the vector map
`timescale 1ns/1ps
module testbench;
  import ivm_pkg::*;
  // ==========================================
  // stimulus and observed signals
  localparam logic [12:0] BOOT = 13'h0e00; // boot base of the run
  logic clk = 1'b0;
  logic reset = 1'b1;
  ivm_cfg_t cfg = '{IVM_VAR_MID, 1'b1, 1'b0, BOOT};
  logic [IVM_NUM_IRQ-1:0] irq_pending = '0;
  logic reset_fetch;
  logic irq_accept;
  ivm_vec_t vec_out;
  int miscompares = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  ivm_core_model core (.clk(clk), .reset_fetch(reset_fetch), .irq_accept(irq_accept));
  ivm_vector_map DUT (.clk(clk), .reset(reset), .cfg(cfg), .reset_fetch(reset_fetch),
    .irq_pending(irq_pending), .irq_accept(irq_accept), .vec_out(vec_out));
  // ==========================================
  // compare one value
  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one request, then answer and drop of valid with the address held
  task automatic req(input logic rst, input logic [24:0] pend, input logic [4:0] num,
      input logic [12:0] addr);
    logic v;
    v = rst | (|pend);
    @(negedge clk);
    irq_pending = pend;
    core.take(rst, 1'b1);
    chk("valid", {12'h000, v}, {12'h000, vec_out.valid});
    if (v) begin
      chk("vec_num", {8'h00, num}, {8'h00, vec_out.vec_num});
      chk("addr", addr, vec_out.addr);
      chk("is_reset", {12'h000, rst}, {12'h000, vec_out.is_reset});
    end
    @(negedge clk);
    irq_pending = '0;
    chk("valid drop", 13'h0000, {12'h000, vec_out.valid});
    if (v) begin
      chk("addr hold", addr, vec_out.addr);
    end
  endtask
  // ==========================================
  // scenarios
  // one-word table, every source; reset wins
  // each source in its own slot
  task automatic t_table;
    req(1'b1, 25'h0000004, 5'h01, 13'h0000);
    for (int i = 0; i < IVM_NUM_IRQ; i++) begin
      req(1'b0, 25'h1 << i, 5'(i + 2), 13'(i + 1));
    end
  endtask
  // fuse and relocation bit in mid and small variants
  task automatic t_boot;
    cfg.boot_reset_select_fuse = 1'b0;
    req(1'b1, 25'h0, 5'h01, BOOT);
    cfg.vector_relocate_bit = 1'b1;
    req(1'b0, 25'h1, 5'h02, BOOT + 13'h0001);
    req(1'b0, 25'h40, 5'h08, BOOT + 13'h0007);
    cfg.variant = IVM_VAR_SMALL;
    req(1'b1, 25'h0, 5'h01, 13'h0000);
    req(1'b0, 25'h1, 5'h02, 13'h0001);
  endtask
  // two-word slots, plain and relocated
  task automatic t_large;
    cfg.variant = IVM_VAR_LARGE;
    req(1'b1, 25'h0, 5'h01, BOOT);
    req(1'b0, 25'h2, 5'h03, BOOT + 13'h0004);
    cfg.vector_relocate_bit = 1'b0;
    req(1'b0, 25'h1, 5'h02, 13'h0002);
    req(1'b0, 25'h1000000, 5'h1a, 13'h0032);
    cfg.boot_reset_select_fuse = 1'b1;
    req(1'b1, 25'h0, 5'h01, 13'h0000);
  endtask
  // lowest pending wins; empty accept is ignored
  task automatic t_prio;
    cfg.variant = IVM_VAR_MID;
    req(1'b0, 25'h0100008, 5'h05, 13'h0004);
    req(1'b0, 25'h0, 5'h00, 13'h0000);
  endtask
  // reset in mid-run clears every held field, then requests resume
  task automatic t_reset;
    req(1'b0, 25'h0000080, 5'h09, 13'h0008);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    chk("reset addr", 13'h0000, vec_out.addr);
    chk("reset vec_num", 13'h0000, {8'h00, vec_out.vec_num});
    chk("reset is_reset", 13'h0000, {12'h000, vec_out.is_reset});
    reset = 1'b0;
    req(1'b0, 25'h0000001, 5'h02, 13'h0001);
  endtask
  // ==========================================
  // verdict and end of run
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #(8 * 3000);
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    chk("reset addr", 13'h0000, vec_out.addr);
    chk("reset valid", 13'h0000, {12'h000, vec_out.valid});
    reset = 1'b0;
    t_table();
    t_boot();
    t_large();
    t_prio();
    t_reset();
    stop_test();
  end
endmodule
